// ### adc_pin_id_channel_regs.sv
// Pin configuration, identification and channel zero registers with the channel sequencer.
`timescale 1ns/10ps
module adc_pin_id_channel_regs
  import adc_regs_pkg::*;
#(
  // Identification code; the value is arbitrary.
  parameter logic [15:0] DEVICE_ID = 16'hA5C3
) (
  // System clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial host port.
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic serialIn,
  output logic serialOut,
  // General pin zero.
  input wire logic pinZeroIn,
  output logic pinZeroOut,
  output logic pinZeroOeN,
  output logic pinZeroInputEnable,
  // General pin one.
  input wire logic pinOneIn,
  output logic pinOneOut,
  output logic pinOneOeN,
  output logic pinOneInputEnable,
  // Channel zero fields toward the sequencer.
  output logic channelZeroEnable,
  output setupSel_t channelZeroSetupSelect,
  output logic [9:0] channelZeroInputs,
  // Other channels and the conversion timing.
  input wire channelMask_t otherChannelEnables,
  input wire setupSelSet_t otherSetupSelects,
  input wire logic conversionDone,
  output channelIdx_t activeChannel,
  output setupSel_t activeSetup
);

  host_bus_if hb ();
  word_t pinConfig_q;
  word_t chZero_q;
  logic pinZeroMeta_q, pinZeroSync_q;
  logic pinOneMeta_q, pinOneSync_q;
  channelMask_t enables;
  channelIdx_t activeChannel_q;
  setupSel_t activeSetup_q;

  // Serial engine that drives the register strobes.
  spi_frame_engine frameEngine (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .serialClk(serialClk),
    .chipSelectN(chipSelectN),
    .serialIn(serialIn),
    .serialOut(serialOut),
    .bus(hb.engine)
  );

  // Step to the next enabled channel after cur, wrapping; hold if none is enabled.
  function automatic channelIdx_t nextChannel(input channelMask_t mask, input channelIdx_t cur);
    channelIdx_t pick;
    channelIdx_t probe;
    logic found;
    pick = cur;
    found = 1'b0;
    for (int i = 1; i <= CHANNEL_COUNT; i++) begin
      probe = channelIdx_t'(cur + channelIdx_t'(i));
      if (mask[probe] && !found) begin
        pick = probe;
        found = 1'b1;
      end
    end
    return pick;
  endfunction : nextChannel

  // Pin levels come from outside the clock domain, so two flops precede any reader.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pinZeroMeta_q <= 1'b0;
      pinZeroSync_q <= 1'b0;
      pinOneMeta_q <= 1'b0;
      pinOneSync_q <= 1'b0;
    end else begin
      pinZeroMeta_q <= pinZeroIn;
      pinZeroSync_q <= pinZeroMeta_q;
      pinOneMeta_q <= pinOneIn;
      pinOneSync_q <= pinOneMeta_q;
    end
  end

  // Pin configuration register; only the six low bits are stored.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pinConfig_q <= PIN_CONFIG_RESET; // R01
    end else if (hb.wrStrobe && hb.addr == PIN_CONFIG_ADDR) begin
      pinConfig_q <= hb.wrData & PIN_CONFIG_MASK;
    end
  end

  // Channel zero register; the reserved bits 11 and 10 never store a one.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      chZero_q <= CH_ZERO_RESET; // R07
    end else if (hb.wrStrobe && hb.addr == CH_ZERO_ADDR) begin
      chZero_q <= hb.wrData & CH_ZERO_MASK; // R08
    end
  end

  // Pin drivers; the enable is low while the pin is driven.
  assign pinZeroOut = pinConfig_q[PIN_ZERO_LEVEL_BIT]; // R05
  assign pinZeroOeN = ~pinConfig_q[PIN_ZERO_OUT_EN_BIT]; // R03
  assign pinZeroInputEnable = pinConfig_q[PIN_ZERO_IN_EN_BIT]; // R01
  assign pinOneOut = pinConfig_q[PIN_ONE_LEVEL_BIT]; // R04
  assign pinOneOeN = ~pinConfig_q[PIN_ONE_OUT_EN_BIT]; // R02
  assign pinOneInputEnable = pinConfig_q[PIN_ONE_IN_EN_BIT];

  // Channel fields handed to the converter.
  assign channelZeroEnable = chZero_q[CH_ENABLE_BIT]; // R09
  assign channelZeroSetupSelect = chZero_q[SETUP_SEL_HI:SETUP_SEL_LO]; // R11
  assign channelZeroInputs = chZero_q[9:0];

  // Read mux. A pin configured as input reads back its sampled level, not the stored bit.
  always_comb begin
    hb.rdData = '0;
    unique case (hb.addr)
      PIN_CONFIG_ADDR: begin
        hb.rdData = pinConfig_q;
        if (pinConfig_q[PIN_ZERO_IN_EN_BIT]) begin
          hb.rdData[PIN_ZERO_LEVEL_BIT] = pinZeroSync_q; // R05
        end
        if (pinConfig_q[PIN_ONE_IN_EN_BIT]) begin
          hb.rdData[PIN_ONE_LEVEL_BIT] = pinOneSync_q; // R04
        end
      end
      ID_ADDR: begin
        hb.rdData = DEVICE_ID; // R06
      end
      CH_ZERO_ADDR: begin
        hb.rdData = chZero_q;
      end
      default: begin
        hb.rdData = '0;
      end
    endcase
  end

  // Writes to the identification address fall through every decoder above and change nothing.
  // R14

  // Channel zero enable joins the enables of the other channels.
  assign enables = {otherChannelEnables[7:1], chZero_q[CH_ENABLE_BIT]};

  // Sequencer: each finished conversion moves to the next enabled channel without host help.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      activeChannel_q <= '0;
    end else if (conversionDone) begin
      activeChannel_q <= nextChannel(enables, activeChannel_q); // R10
    end
  end

  // Setup of the active channel; one cycle behind the channel so the output is a flop.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      activeSetup_q <= '0;
    end else if (activeChannel_q == '0) begin
      activeSetup_q <= chZero_q[SETUP_SEL_HI:SETUP_SEL_LO]; // R12
    end else begin
      activeSetup_q <= otherSetupSelects[activeChannel_q]; // R12
    end
  end

  assign activeChannel = activeChannel_q;
  assign activeSetup = activeSetup_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_pin_zero_input: assert property ( // R01
    (hb.rdStrobe && hb.addr == PIN_CONFIG_ADDR && pinConfig_q[PIN_ZERO_IN_EN_BIT])
      |-> hb.rdData[PIN_ZERO_LEVEL_BIT] == pinZeroSync_q)
    else $error("pin zero input readback wrong");
  a_pin_one_drive: assert property ( // R02
    (hb.wrStrobe && hb.addr == PIN_CONFIG_ADDR)
      |=> pinOneOeN == !$past(hb.wrData[PIN_ONE_OUT_EN_BIT]))
    else $error("pin one output enable did not follow the write");
  a_pin_zero_drive: assert property ( // R03
    (hb.wrStrobe && hb.addr == PIN_CONFIG_ADDR)
      |=> pinZeroOeN == !$past(hb.wrData[PIN_ZERO_OUT_EN_BIT])
        && pinZeroOut == $past(hb.wrData[PIN_ZERO_LEVEL_BIT]))
    else $error("pin zero drive did not follow the write");
  a_pin_one_readback: assert property ( // R04
    (hb.rdStrobe && hb.addr == PIN_CONFIG_ADDR && !pinConfig_q[PIN_ONE_IN_EN_BIT])
      |-> hb.rdData[PIN_ONE_LEVEL_BIT] == pinOneOut)
    else $error("pin one output readback wrong");
  a_id_read_value: assert property ( // R06
    (hb.rdStrobe && hb.addr == ID_ADDR) |-> hb.rdData == DEVICE_ID)
    else $error("identification read wrong");
  a_chzero_reset_value: assert property ( // R07
    $rose(resetn) |-> chZero_q == CH_ZERO_RESET)
    else $error("channel zero reset value wrong");
  a_channel_enable_write: assert property ( // R09
    (hb.wrStrobe && hb.addr == CH_ZERO_ADDR)
      |=> channelZeroEnable == $past(hb.wrData[CH_ENABLE_BIT]))
    else $error("channel enable did not follow the write");
  a_setup_select_write: assert property ( // R11
    (hb.wrStrobe && hb.addr == CH_ZERO_ADDR)
      |=> channelZeroSetupSelect == $past(hb.wrData[SETUP_SEL_HI:SETUP_SEL_LO]))
    else $error("setup select did not follow the write");
  a_sequence_step: assert property ( // R10
    (conversionDone && $countones(enables) > 1) |=> activeChannel_q != $past(activeChannel_q))
    else $error("sequencer did not step");
  a_active_setup: assert property ( // R12
    (activeChannel_q == '0) |=> activeSetup_q == $past(chZero_q[SETUP_SEL_HI:SETUP_SEL_LO]))
    else $error("active setup not channel zero setup");
  a_id_write_ignored: assert property ( // R14
    (hb.wrStrobe && hb.addr == ID_ADDR) |=> $stable(pinConfig_q) && $stable(chZero_q))
    else $error("identification write changed a register");

  c_chzero_write: cover property (hb.wrStrobe && hb.addr == CH_ZERO_ADDR);
  c_id_read: cover property (hb.rdStrobe && hb.addr == ID_ADDR);
  c_pin_input_read: cover property (hb.rdStrobe && hb.addr == PIN_CONFIG_ADDR
    && pinConfig_q[PIN_ZERO_IN_EN_BIT]);
  c_sequence_step: cover property (conversionDone && $countones(enables) > 1);

endmodule : adc_pin_id_channel_regs

// ### adc_regs_pkg.sv
// Constants, types and field layouts shared by the pin, identification and channel registers.
// Operation
// R01 - Pin configuration bit 4 set to 1 turns general pin zero into an input; it resets to 0.
// R02 - Pin configuration bit 3 set to 1 makes general pin one drive as an output; it resets to 0.
// R03 - Pin configuration bit 2 set to 1 makes general pin zero drive as an output; it resets to 0.
// R04 - Bit 1 is the level driven on pin one as an output and reads the sampled pin as an input.
// R05 - Bit 0 is the level driven on pin zero as an output and reads the sampled pin as an input.
// R06 - A read-only identification register at address 0x07 returns a fixed 16-bit code.
// R07 - Channel register zero sits at address 0x10, is 16 bits wide and resets to 0x8001.
// R08 - A channel register says whether its channel is active, its inputs and its setup.
// R09 - Bit 15 of channel register zero enables channel zero and resets to 1.
// R10 - With more than one channel enabled the converter steps through them on its own.
// R11 - Bits 14 to 12 of the channel register select one of eight setups and reset to 000.
// R12 - The selected setup applies its configuration, filter, offset and gain registers.
// R13 - The host writes one setup code to all active channels when they are to share a setup.
// R14 - Writes to the identification register are ignored and leave it unchanged.
package adc_regs_pkg;

  // Register addresses seen in the command byte.
  localparam logic [5:0] PIN_CONFIG_ADDR = 6'h06;
  localparam logic [5:0] ID_ADDR = 6'h07;
  localparam logic [5:0] CH_ZERO_ADDR = 6'h10;

  // Pin configuration field positions and reset value.
  localparam int unsigned PIN_ZERO_LEVEL_BIT = 0;
  localparam int unsigned PIN_ONE_LEVEL_BIT = 1;
  localparam int unsigned PIN_ZERO_OUT_EN_BIT = 2;
  localparam int unsigned PIN_ONE_OUT_EN_BIT = 3;
  localparam int unsigned PIN_ZERO_IN_EN_BIT = 4;
  localparam int unsigned PIN_ONE_IN_EN_BIT = 5;
  localparam logic [15:0] PIN_CONFIG_RESET = 16'h0000;
  localparam logic [15:0] PIN_CONFIG_MASK = 16'h003F;

  // Channel register field positions, reset value and writable bits.
  localparam int unsigned CH_ENABLE_BIT = 15;
  localparam int unsigned SETUP_SEL_HI = 14;
  localparam int unsigned SETUP_SEL_LO = 12;
  localparam logic [15:0] CH_ZERO_RESET = 16'h8001;
  localparam logic [15:0] CH_ZERO_MASK = 16'hF3FF;

  // Serial frame layout: command byte, then sixteen data bits.
  localparam int unsigned CMD_WEN_N_BIT = 7;
  localparam int unsigned CMD_READ_BIT = 6;
  localparam logic [4:0] CMD_LAST_BIT = 5'h07;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
  localparam logic [4:0] BIT_STEP = 5'h01;

  // Channel count of the sequencer.
  localparam int unsigned CHANNEL_COUNT = 8;

  typedef logic [15:0] word_t;
  typedef logic [5:0] regAddr_t;
  typedef logic [2:0] setupSel_t;
  typedef logic [2:0] channelIdx_t;
  typedef logic [7:0] channelMask_t;
  typedef logic [7:1][2:0] setupSelSet_t;
  typedef enum logic [2:0] {FRAME_IDLE, FRAME_CMD, FRAME_WRITE, FRAME_READ, FRAME_HOLD} frame_t;

endpackage : adc_regs_pkg

// ### host_bus_if.sv
// Register access strobes between the serial frame engine and the register bank.
`timescale 1ns/10ps
interface host_bus_if;
  import adc_regs_pkg::*;
  regAddr_t addr;
  logic wrStrobe;
  word_t wrData;
  logic rdStrobe;
  word_t rdData;

  modport engine (output addr, output wrStrobe, output wrData, output rdStrobe, input rdData);
  modport regs (input addr, input wrStrobe, input wrData, input rdStrobe, output rdData);
endinterface : host_bus_if

// ### spi_frame_engine.sv
// Serial port engine: oversamples the host's clock and turns frames into register strobes.
`timescale 1ns/10ps
module spi_frame_engine
  import adc_regs_pkg::*;
(
  // System clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial pins from the host.
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic serialIn,
  output logic serialOut,
  // Register strobes.
  host_bus_if.engine bus
);

  logic clkMeta_q, clkSync_q, clkPrev_q;
  logic csMeta_q, csSync_q;
  logic dinMeta_q, dinSync_q;
  logic riseEdge, fallEdge;
  frame_t state_q;
  logic [4:0] bitCount_q;
  word_t rxShift_q;
  word_t txShift_q;
  logic [7:0] cmdByte;

  // Every pin passes two flops; edges are found on the second stage only.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clkMeta_q <= 1'b1;
      clkSync_q <= 1'b1;
      clkPrev_q <= 1'b1;
      csMeta_q <= 1'b1;
      csSync_q <= 1'b1;
      dinMeta_q <= 1'b0;
      dinSync_q <= 1'b0;
    end else begin
      clkMeta_q <= serialClk;
      clkSync_q <= clkMeta_q;
      clkPrev_q <= clkSync_q;
      csMeta_q <= chipSelectN;
      csSync_q <= csMeta_q;
      dinMeta_q <= serialIn;
      dinSync_q <= dinMeta_q;
    end
  end

  // Data and clock share the same delay, so data is still valid at the detected rise.
  assign riseEdge = clkSync_q & ~clkPrev_q & ~csSync_q;
  assign fallEdge = ~clkSync_q & clkPrev_q & ~csSync_q;
  assign cmdByte = {rxShift_q[6:0], dinSync_q};

  // Frame sequence; raising chip select abandons any partial frame.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= FRAME_IDLE;
      bitCount_q <= '0;
      rxShift_q <= '0;
      bus.addr <= '0;
      bus.wrStrobe <= 1'b0;
      bus.wrData <= '0;
      bus.rdStrobe <= 1'b0;
    end else begin
      bus.wrStrobe <= 1'b0;
      bus.rdStrobe <= 1'b0;
      if (csSync_q) begin
        state_q <= FRAME_IDLE;
        bitCount_q <= '0;
      end else if (state_q == FRAME_IDLE) begin
        state_q <= FRAME_CMD;
      end else if (riseEdge) begin
        rxShift_q <= {rxShift_q[14:0], dinSync_q};
        bitCount_q <= bitCount_q + BIT_STEP;
        unique case (state_q)
          FRAME_CMD: begin
            if (bitCount_q == CMD_LAST_BIT) begin
              bus.addr <= cmdByte[5:0];
              // A command without the write-enable low is not for us.
              if (cmdByte[CMD_WEN_N_BIT]) begin
                state_q <= FRAME_HOLD;
              end else if (cmdByte[CMD_READ_BIT]) begin
                state_q <= FRAME_READ;
                bus.rdStrobe <= 1'b1;
              end else begin
                state_q <= FRAME_WRITE;
              end
            end
          end
          FRAME_WRITE: begin
            if (bitCount_q == FRAME_LAST_BIT) begin
              bus.wrData <= {rxShift_q[14:0], dinSync_q};
              bus.wrStrobe <= 1'b1;
              state_q <= FRAME_HOLD;
            end
          end
          FRAME_READ: begin
            if (bitCount_q == FRAME_LAST_BIT) begin
              state_q <= FRAME_HOLD;
            end
          end
          FRAME_HOLD, FRAME_IDLE: begin
            state_q <= FRAME_HOLD;
          end
        endcase
      end
    end
  end

  // Read data is captured while the strobe is high and shifted out on falling edges.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txShift_q <= '0;
      serialOut <= 1'b0;
    end else if (csSync_q) begin
      serialOut <= 1'b0;
    end else if (bus.rdStrobe) begin
      txShift_q <= bus.rdData;
    end else if (fallEdge && state_q == FRAME_READ) begin
      serialOut <= txShift_q[15];
      txShift_q <= {txShift_q[14:0], 1'b0};
    end
  end

endmodule : spi_frame_engine

// ### spi_host_model.sv
// Host model: a serial port master in clock mode 3 that sends one command per frame.
`timescale 1ns/10ps
module spi_host_model
  import adc_regs_pkg::*;
(
  // System clock that paces the host.
  input wire logic sys_clk,
  // Serial pins toward the device.
  output logic serialClk,
  output logic chipSelectN,
  output logic serialIn,
  input wire logic serialOut,
  // Read results.
  output logic rdValid,
  output word_t rdWord
);
  // Half period of the serial clock in system cycles; the device needs three at least.
  int halfPeriod = 5;

  // Serial clock idles high and stands still between frames.
  initial begin
    serialClk = 1'b1;
    chipSelectN = 1'b1;
    serialIn = 1'b0;
    rdValid = 1'b0;
    rdWord = 16'h0000;
  end

  // One whole frame: command byte, then sixteen data bits, both MSB first.
  task automatic runFrame(input logic [7:0] cmd, input word_t data);
    logic [23:0] bits;
    bits = {cmd, data};
    @(negedge sys_clk);
    chipSelectN = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (halfPeriod) @(negedge sys_clk);
      serialClk = 1'b0;
      serialIn = bits[i];
      repeat (halfPeriod) @(negedge sys_clk);
      serialClk = 1'b1;
      if (i < 16) begin
        rdWord[i] = serialOut;
      end
    end
    repeat (halfPeriod) @(negedge sys_clk);
    chipSelectN = 1'b1;
    // A released line shows the inverse of the last bit, so a stale copy is never trusted.
    serialIn = ~bits[0];
    if (cmd[CMD_READ_BIT]) begin
      rdValid = 1'b1;
      @(negedge sys_clk);
      rdValid = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
  endtask : runFrame
endmodule : spi_host_model

// ### testbench.sv
// Self-checking bench for the pin, identification and channel zero registers.
`timescale 1ns/10ps
module testbench;
  import adc_regs_pkg::*;
  // Identification code for this run; the value is arbitrary.
  localparam logic [15:0] TEST_ID = 16'h5A3C;
  logic sys_clk, resetn, serialClk, chipSelectN, serialIn, serialOut, rdValid, portValid;
  logic pinZeroIn, pinZeroOut, pinZeroOeN, pinZeroInputEnable, extZero;
  logic pinOneIn, pinOneOut, pinOneOeN, pinOneInputEnable, extOne;
  logic channelZeroEnable, conversionDone;
  logic [9:0] channelZeroInputs;
  setupSel_t channelZeroSetupSelect, activeSetup;
  channelMask_t otherChannelEnables, en;
  setupSelSet_t otherSetupSelects;
  channelIdx_t activeChannel, cur, c;
  word_t rdWord, portWord, v, got, pinCfg, chCfg, pinWord, seqWord;
  word_t expQ[$];
  int nFail = 0;
  int numChecks = 0;

  // The pin wire follows the device while it drives, otherwise the outside level.
  assign pinZeroIn = pinZeroOeN ? extZero : pinZeroOut;
  assign pinOneIn = pinOneOeN ? extOne : pinOneOut;
  assign pinWord = {6'h00, channelZeroEnable, channelZeroSetupSelect, pinOneInputEnable,
                    pinZeroInputEnable, ~pinOneOeN, ~pinZeroOeN, pinOneOut, pinZeroOut};
  assign seqWord = {10'h000, activeSetup, activeChannel};

  adc_pin_id_channel_regs #(.DEVICE_ID(TEST_ID)) dut (.sys_clk(sys_clk), .resetn(resetn),
    .serialClk(serialClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
    .serialOut(serialOut), .pinZeroIn(pinZeroIn), .pinZeroOut(pinZeroOut),
    .pinZeroOeN(pinZeroOeN), .pinZeroInputEnable(pinZeroInputEnable), .pinOneIn(pinOneIn),
    .pinOneOut(pinOneOut), .pinOneOeN(pinOneOeN), .pinOneInputEnable(pinOneInputEnable),
    .channelZeroEnable(channelZeroEnable), .channelZeroSetupSelect(channelZeroSetupSelect),
    .channelZeroInputs(channelZeroInputs), .otherChannelEnables(otherChannelEnables),
    .otherSetupSelects(otherSetupSelects), .conversionDone(conversionDone),
    .activeChannel(activeChannel), .activeSetup(activeSetup));

  spi_host_model host (.sys_clk(sys_clk), .serialClk(serialClk), .chipSelectN(chipSelectN),
    .serialIn(serialIn), .serialOut(serialOut), .rdValid(rdValid), .rdWord(rdWord));

  // Clock at 40 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Expected readback of the pin register: input mode returns the wire level.
  // The wire is modelled from the configuration, so a wrong drive cannot hide itself.
  function automatic word_t pinRead(input word_t p);
    word_t r = p;
    if (p[4]) r[0] = p[2] ? p[0] : extZero;
    if (p[5]) r[1] = p[3] ? p[1] : extOne;
    return r;
  endfunction : pinRead

  function automatic word_t portsOf(input word_t ch, input word_t pin);
    return {6'h00, ch[15:12], pin[5:0]};
  endfunction : portsOf

  function automatic setupSel_t setupOf(input channelIdx_t ch);
    return (ch == 3'h0) ? chCfg[14:12] : otherSetupSelects[ch];
  endfunction : setupOf

  task automatic finishTest();
    $display("Checks made: %0d, mismatches: %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finishTest

  task automatic regWrite(input regAddr_t a, input word_t d);
    host.runFrame({2'b00, a}, d);
  endtask : regWrite

  task automatic regRead(input regAddr_t a, input word_t e);
    expQ.push_back(e);
    host.runFrame({2'b01, a}, word_t'($urandom()));
  endtask : regRead

  // Hands a port snapshot to the monitor together with its expected value.
  task automatic observe(input word_t e, input word_t o);
    expQ.push_back(e);
    portWord = o;
    portValid = 1'b1;
    @(negedge sys_clk);
    portValid = 1'b0;
    // Let an edge pass so a following snapshot never lowers and raises the flag at once.
    @(negedge sys_clk);
  endtask : observe

  // Monitor: every result that appears is paired with the oldest expectation.
  always @(posedge sys_clk) begin
    if (rdValid || portValid) begin
      got = rdValid ? rdWord : portWord;
      numChecks++;
      if (expQ.size() == 0 || expQ[0] !== got) begin
        nFail++;
        $display("ERROR at %0t: got %h expected %h", $time, got, expQ.size() ? expQ[0] : 'x);
      end
      if (expQ.size() != 0) void'(expQ.pop_front());
    end
  end

  // Watchdog, well beyond the forty-six frames of the run.
  initial begin
    #2000000;
    nFail++;
    $display("Watchdog expired at %0t", $time);
    finishTest();
  end

  initial begin
    void'($urandom(32'hA714));
    {resetn, extZero, extOne, conversionDone, portValid, portWord} = '0;
    otherChannelEnables = 8'h00;
    otherSetupSelects = '0;
    pinCfg = PIN_CONFIG_RESET;
    chCfg = CH_ZERO_RESET;
    repeat (12) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    observe(portsOf(CH_ZERO_RESET, PIN_CONFIG_RESET), pinWord);
    regRead(CH_ZERO_ADDR, 16'h8001);
    regRead(PIN_CONFIG_ADDR, 16'h0000);
    regRead(ID_ADDR, TEST_ID);
    regWrite(ID_ADDR, ~TEST_ID);
    regRead(ID_ADDR, TEST_ID);
    regRead(6'h3F, 16'h0000);
    // Pin modes with random outside levels, including pins that read themselves.
    for (int i = 0; i < 10; i++) begin
      v = word_t'($urandom());
      extZero = v[8];
      extOne = v[9];
      regWrite(PIN_CONFIG_ADDR, v);
      pinCfg = v & PIN_CONFIG_MASK;
      observe(portsOf(chCfg, pinCfg), pinWord);
      regRead(PIN_CONFIG_ADDR, pinRead(pinCfg));
    end
    // Every setup code, with a slow host clock.
    host.halfPeriod = 8;
    for (int s = 0; s < 8; s++) begin
      v = word_t'($urandom());
      v[14:12] = s[2:0];
      regWrite(CH_ZERO_ADDR, v);
      chCfg = v & CH_ZERO_MASK;
      observe(portsOf(chCfg, pinCfg), pinWord);
      observe({6'h00, chCfg[9:0]}, {6'h00, channelZeroInputs});
      regRead(CH_ZERO_ADDR, chCfg);
    end
    host.halfPeriod = 5;
    // A command whose top bit is set must be dropped.
    host.runFrame({2'b10, CH_ZERO_ADDR}, ~chCfg);
    regRead(CH_ZERO_ADDR, chCfg);
    // Sequencer with distinct setups on channels 1 to 7; channel zero shares setup 6 with channel 1.
    regWrite(CH_ZERO_ADDR, 16'hE000);
    chCfg = 16'hE000;
    for (int k = 1; k < 8; k++) otherSetupSelects[k] = 3'(7 - k);
    otherChannelEnables = 8'($urandom()) | 8'h24;
    // No conversion has finished since reset, so the sequencer still sits on channel zero.
    cur = 3'h0;
    for (int n = 0; n < 12; n++) begin
      if (n == 9) begin
        otherChannelEnables = 8'h00;
        regWrite(CH_ZERO_ADDR, 16'h0000);
        chCfg = 16'h0000;
      end
      en = {otherChannelEnables[7:1], chCfg[15]};
      // The nearest enabled channel after the current one wins; none other means hold.
      c = cur;
      for (int k = 7; k >= 1; k--) begin
        if (en[channelIdx_t'(int'(cur) + k)]) c = channelIdx_t'(int'(cur) + k);
      end
      cur = c;
      conversionDone = 1'b1;
      @(negedge sys_clk);
      conversionDone = 1'b0;
      repeat (2) @(negedge sys_clk);
      observe({10'h000, setupOf(cur), cur}, seqWord);
    end
    repeat (4) @(negedge sys_clk);
    if (expQ.size() != 0) begin
      nFail++;
      $display("ERROR at %0t: got %h expected %h", $time, 0, expQ.size());
    end
    finishTest();
  end
endmodule : testbench
